// *** hdl/switch_port_interrupt_aggregator_params.svh ***
// Purpose: constants of the switch port interrupt aggregator
// Assumes: 32-bit APB, byte offsets, one register per word
`ifndef SWITCH_PORT_INTERRUPT_AGGREGATOR_PARAMS_SVH
`define SWITCH_PORT_INTERRUPT_AGGREGATOR_PARAMS_SVH

// register byte offsets
`define OFS_DS_MSI_EN      8'h00
`define OFS_DS_INTX_DIS    8'h04
`define OFS_DS_BW_NOTIFY   8'h08
`define OFS_US_CTRL        8'h0C
`define OFS_PM_CAP         8'h10
`define OFS_US_INTR_STS    8'h14
`define OFS_DS_INTR_STS    8'h18
`define OFS_IRQ_STATUS     8'h1C
`define OFS_IRQ_MASK       8'h20

// upstream control bits
`define US_MSI_EN_BIT      0
`define US_INTX_DIS_BIT    1
`define US_UNLOCK_BIT      2

// power management capability field
`define PM_NXT_LSB         0
`define PM_NXT_MSB         7
`define PM_LISTED_BIT      8
`define MSI_CAP_PTR        8'hD0
`define PM_NXT_RESET       8'h00

// interrupt status bits
`define IRQ_PARITY_BIT     0
`define IRQ_CFGRD_BIT      1
`define IRQ_BITS           2

// swizzle distances per downstream port index (ports 2..5)
`define SWZ_PORT2          2
`define SWZ_PORT3          1
`define SWZ_PORT4          0
`define SWZ_PORT5          3

`endif

// *** hdl/switch_port_interrupt_aggregator_pkg.sv ***
// Purpose: types of the switch port interrupt aggregator
// Assumes: four legacy lines A..D
// Notes:   constants live in the params header
package switch_port_interrupt_aggregator_pkg;

  typedef logic [3:0] intx_t;
  typedef logic [1:0] line_t;

  typedef enum logic {
    MSG_DEASSERT,
    MSG_ASSERT
  } msg_kind_e;

endpackage : switch_port_interrupt_aggregator_pkg

// *** hdl/ds_port_intr.sv ***
// Purpose: one downstream port's interrupt source and INTx state
// Assumes: received INTx messages arrive as one-cycle pulses
// Notes:   state is pre-mapping; remapping happens upstream only
`timescale 1ns/1ps
module ds_port_intr
  import switch_port_interrupt_aggregator_pkg::*;
(
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  rst,
  // sources
  input  wire logic  hotPlugIrq,
  input  wire logic  bwMgmtStatusBit,
  input  wire logic  autonomousBwStatusBit,
  input  wire logic  bwMgmtIntEn,
  input  wire logic  autonomousBwIntEn,
  // configuration
  input  wire logic  msiEnable,
  input  wire logic  legacyIntrDisable,
  input  wire logic  linkUp,
  // messages from downstream partner
  input  wire intx_t rxAssert,
  input  wire intx_t rxDeassert,
  // results
  output intx_t      portIntx,
  output logic       msiReq
);

  logic  cond;
  logic  cond_r;
  logic  ownIntA_r;
  intx_t rxState_r;

  // masked or cleared bits drop it
  assign cond = hotPlugIrq | (bwMgmtStatusBit & bwMgmtIntEn)
              | (autonomousBwStatusBit & autonomousBwIntEn);

  always_ff @(posedge core_clk) begin
    if (rst) cond_r <= 1'b0;
    else     cond_r <= cond;
  end

  always_ff @(posedge core_clk) begin
    if (rst) msiReq <= 1'b0;
    else     msiReq <= cond & ~cond_r & msiEnable;
  end

  always_ff @(posedge core_clk) begin
    if (rst || !linkUp) begin
      ownIntA_r <= 1'b0;
    end else if (!msiEnable && !legacyIntrDisable) begin
      if (cond & ~cond_r)
        ownIntA_r <= 1'b1;
      else if (~cond & cond_r)
        ownIntA_r <= 1'b0;
    end
  end

  // received wires; assert wins a same-cycle clash
  always_ff @(posedge core_clk) begin
    if (rst || !linkUp) begin
      rxState_r <= '0;
    end else begin
      rxState_r <= (rxState_r & ~rxDeassert) | rxAssert;
    end
  end

  assign portIntx = rxState_r | {3'b000, ownIntA_r};

endmodule : ds_port_intr

// *** hdl/switch_port_interrupt_aggregator.sv ***
// Purpose: port interrupts and legacy INTx emulation for a 5-port switch
// Assumes: APB slave, 32-bit data; downstream ports 2..5 as index 0..3
// Notes:   one INTx message request outstanding at a time
`timescale 1ns/1ps
`include "switch_port_interrupt_aggregator_params.svh"
module switch_port_interrupt_aggregator
  import switch_port_interrupt_aggregator_pkg::*;
#(
  parameter int NDS = 4
)(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // internal error events, one-cycle pulses
  input  wire logic             parityErr,
  input  wire logic             cfgReadErr,
  // downstream port sources
  input  wire logic [NDS-1:0]   hotPlugIrq,
  input  wire logic [NDS-1:0]   bwMgmtStatusBit,
  input  wire logic [NDS-1:0]   autonomousBwStatusBit,
  input  wire logic [NDS-1:0]   dsLinkUp,
  input  wire logic [4*NDS-1:0] rxAssert,
  input  wire logic [4*NDS-1:0] rxDeassert,
  // MSI requests to switch core, routed upstream
  output logic      [NDS-1:0]   dsMsiReq,
  output logic                  usMsiReq,
  // INTx message request to switch core
  output logic                  msgValid,
  output logic                  msgAssert,
  output logic      [1:0]       msgLine,
  input  wire logic             msgReady,
  // capability list view
  output logic                  msiCapListed,
  // interrupt line
  output logic                  irq
);

  // ---------------------------------------------------------------
  // registers
  logic [NDS-1:0]          dsMsiEn_r;
  logic [NDS-1:0]          dsIntxDis_r;
  logic [2*NDS-1:0]        dsBwNotify_r;
  logic [2:0]              usCtrl_r;
  logic [7:0]              capNextPointer_r;
  logic [`IRQ_BITS-1:0]    irqStatus_r;
  logic [`IRQ_BITS-1:0]    irqMask_r;
  logic [`IRQ_BITS-1:0]    irqStatus_nxt;

  // apb decode
  logic                    setupAcc;
  logic                    wrDone;
  logic                    rdHit;
  logic [31:0]             rdData;
  logic                    hit;

  // write strobes, one per writable register
  logic                    wrMsiEn;
  logic                    wrIntxDis;
  logic                    wrBwNotify;
  logic                    wrUsCtrl;
  logic                    wrPmCap;
  logic                    wrIrqSts;
  logic                    wrIrqMask;

  // interrupt paths
  intx_t                   portIntx [NDS];
  logic  [NDS-1:0]         portMsi;
  intx_t                   upAgg;
  intx_t                   sentState_r;
  logic                    usCond;
  logic                    usCond_r;
  logic                    usIntA_r;
  logic [4*NDS-1:0]        dsStsFlat;
  logic                    evtPending;
  line_t                   evtLine;
  intx_t                   diff;

  // ---------------------------------------------------------------
  // mapping happens here only; ports keep their own line view
  // rotate a line vector: out[L] = x[(L+k) mod 4]
  function automatic intx_t swizzle(input intx_t x, input int k);
    intx_t o;
    o = '0;
    for (int l = 0; l < 4; l++) begin
      o[l] = x[(l + k) % 4];
    end
    return o;
  endfunction : swizzle

  function automatic int swzDist(input int p);
    int d;
    d = `SWZ_PORT4;
    case (p)
      0:       d = `SWZ_PORT2;
      1:       d = `SWZ_PORT3;
      2:       d = `SWZ_PORT4;
      3:       d = `SWZ_PORT5;
      default: d = `SWZ_PORT4;
    endcase
    return d;
  endfunction : swzDist

  // shared address match behind every write strobe
  function automatic logic wrSel(input logic       done,
                                 input logic [7:0] a,
                                 input logic [7:0] ofs);
    return done && (a == ofs);
  endfunction : wrSel

  // ---------------------------------------------------------------
  // one wait state keeps prdata a plain register off the decode
  // apb: one wait state, write takes effect at the pready edge
  assign setupAcc = psel & penable & ~pready;
  assign wrDone   = psel & penable & pready & pwrite & ~pslverr;

  // write strobes decoded once, shared by the register blocks
  assign wrMsiEn    = wrSel(wrDone, paddr, `OFS_DS_MSI_EN);
  assign wrIntxDis  = wrSel(wrDone, paddr, `OFS_DS_INTX_DIS);
  assign wrBwNotify = wrSel(wrDone, paddr, `OFS_DS_BW_NOTIFY);
  assign wrUsCtrl   = wrSel(wrDone, paddr, `OFS_US_CTRL);
  assign wrPmCap    = wrSel(wrDone, paddr, `OFS_PM_CAP);
  assign wrIrqSts   = wrSel(wrDone, paddr, `OFS_IRQ_STATUS);
  assign wrIrqMask  = wrSel(wrDone, paddr, `OFS_IRQ_MASK);

  always_comb begin
    rdData = '0;
    hit    = 1'b1;
    case (paddr)
      `OFS_DS_MSI_EN:    rdData[NDS-1:0]   = dsMsiEn_r;
      `OFS_DS_INTX_DIS:  rdData[NDS-1:0]   = dsIntxDis_r;
      `OFS_DS_BW_NOTIFY: rdData[2*NDS-1:0] = dsBwNotify_r;
      `OFS_US_CTRL:      rdData[2:0]       = usCtrl_r;
      `OFS_PM_CAP: begin
        rdData[`PM_NXT_MSB:`PM_NXT_LSB] = capNextPointer_r;
        rdData[`PM_LISTED_BIT]          = msiCapListed;
      end
      `OFS_US_INTR_STS:  rdData[3:0]       = upAgg;
      `OFS_DS_INTR_STS:  rdData[4*NDS-1:0] = dsStsFlat;
      `OFS_IRQ_STATUS:   rdData[`IRQ_BITS-1:0] = irqStatus_r;
      `OFS_IRQ_MASK:     rdData[`IRQ_BITS-1:0] = irqMask_r;
      default:           hit = 1'b0;
    endcase
  end

  assign rdHit = hit;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setupAcc;
      // only unmapped offsets err; writes to read-only fields drop
      pslverr <= setupAcc & ~rdHit;
      // unmapped reads return zero
      prdata  <= (setupAcc & ~pwrite) ? rdData : '0;
    end
  end

  // ---------------------------------------------------------------
  // control registers, one block each so a strobe cannot leak across
  always_ff @(posedge core_clk) begin
    if (rst)          dsMsiEn_r <= '0;
    else if (wrMsiEn) dsMsiEn_r <= pwdata[NDS-1:0];
  end

  always_ff @(posedge core_clk) begin
    if (rst)            dsIntxDis_r <= '0;
    else if (wrIntxDis) dsIntxDis_r <= pwdata[NDS-1:0];
  end

  always_ff @(posedge core_clk) begin
    if (rst)             dsBwNotify_r <= '0;
    else if (wrBwNotify) dsBwNotify_r <= pwdata[2*NDS-1:0];
  end

  always_ff @(posedge core_clk) begin
    if (rst)           usCtrl_r <= '0;
    else if (wrUsCtrl) usCtrl_r <= pwdata[2:0];
  end

  always_ff @(posedge core_clk) begin
    if (rst)            irqMask_r <= '0;
    else if (wrIrqMask) irqMask_r <= pwdata[`IRQ_BITS-1:0];
  end

  // next pointer writable only when unlocked
  always_ff @(posedge core_clk) begin
    if (rst) begin
      capNextPointer_r <= `PM_NXT_RESET;
    end else if (wrPmCap && usCtrl_r[`US_UNLOCK_BIT]) begin
      capNextPointer_r <= pwdata[`PM_NXT_MSB:`PM_NXT_LSB];
    end
  end

  // listed when pointing at MSI capability
  // registered compare: listing shows one cycle after the write
  always_ff @(posedge core_clk) begin
    if (rst) msiCapListed <= 1'b0;
    else     msiCapListed <= (capNextPointer_r == `MSI_CAP_PTR);
  end

  // ---------------------------------------------------------------
  // sticky error status; set wins over write-one-to-clear
  // so an error landing in the clearing cycle is never lost
  always_comb begin
    irqStatus_nxt = irqStatus_r;
    if (wrIrqSts) begin
      irqStatus_nxt = irqStatus_nxt & ~pwdata[`IRQ_BITS-1:0];
    end
    irqStatus_nxt[`IRQ_PARITY_BIT] = irqStatus_nxt[`IRQ_PARITY_BIT]
                                     | parityErr;
    irqStatus_nxt[`IRQ_CFGRD_BIT]  = irqStatus_nxt[`IRQ_CFGRD_BIT]
                                     | cfgReadErr;
  end

  always_ff @(posedge core_clk) begin
    if (rst) irqStatus_r <= '0;
    else     irqStatus_r <= irqStatus_nxt;
  end

  assign usCond = |(irqStatus_r & irqMask_r);

  always_ff @(posedge core_clk) begin
    if (rst) usCond_r <= 1'b0;
    else     usCond_r <= usCond;
  end

  // registered so the pin never glitches while status and mask settle
  always_ff @(posedge core_clk) begin
    if (rst) irq <= 1'b0;
    else     irq <= usCond;
  end

  always_ff @(posedge core_clk) begin
    if (rst) usMsiReq <= 1'b0;
    else     usMsiReq <= usCond & ~usCond_r & usCtrl_r[`US_MSI_EN_BIT];
  end

  // upstream error as legacy INTA
  // msi on or intx off at a negation leaves the wire as it was
  always_ff @(posedge core_clk) begin
    if (rst) begin
      usIntA_r <= 1'b0;
    end else if (!usCtrl_r[`US_MSI_EN_BIT]
                 && !usCtrl_r[`US_INTX_DIS_BIT]) begin
      if (usCond & ~usCond_r)
        usIntA_r <= 1'b1;
      else if (~usCond & usCond_r)
        usIntA_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // downstream ports
  // four line states per port
  // no remapping inside the port
  // link-down clearing lives inside each port
  for (genvar p = 0; p < NDS; p++) begin : g_ds
    ds_port_intr u_port (
      .core_clk              (core_clk),
      .rst                   (rst),
      .hotPlugIrq            (hotPlugIrq[p]),
      .bwMgmtStatusBit       (bwMgmtStatusBit[p]),
      .autonomousBwStatusBit (autonomousBwStatusBit[p]),
      .bwMgmtIntEn           (dsBwNotify_r[2*p]),
      .autonomousBwIntEn     (dsBwNotify_r[2*p+1]),
      .msiEnable             (dsMsiEn_r[p]),
      .legacyIntrDisable     (dsIntxDis_r[p]),
      .linkUp                (dsLinkUp[p]),
      .rxAssert              (rxAssert[4*p +: 4]),
      .rxDeassert            (rxDeassert[4*p +: 4]),
      .portIntx              (portIntx[p]),
      .msiReq                (portMsi[p])
    );
    assign dsStsFlat[4*p +: 4] = portIntx[p];
  end

  always_ff @(posedge core_clk) begin
    if (rst) dsMsiReq <= '0;
    else     dsMsiReq <= portMsi;
  end

  always_comb begin
    // upstream own error rides on INTA like a downstream port
    upAgg = {3'b000, usIntA_r};
    for (int p = 0; p < NDS; p++) begin
      upAgg = upAgg | swizzle(portIntx[p], swzDist(p));
    end
  end

  // ---------------------------------------------------------------
  // INTx messages toward the root
  assign diff = upAgg ^ sentState_r;

  always_comb begin
    evtPending = 1'b0;
    evtLine    = '0;
    for (int l = 3; l >= 0; l--) begin
      if (diff[l]) begin
        evtPending = 1'b1;
        evtLine    = line_t'(l);
      end
    end
  end

  // a line that flips back before its turn sends nothing; lowest
  // changed line goes first, the others wait for the next slot
  // at most one message per state change
  always_ff @(posedge core_clk) begin
    if (rst) begin
      msgValid    <= 1'b0;
      msgAssert   <= 1'b0;
      msgLine     <= '0;
      sentState_r <= '0;
    end else if (!msgValid || msgReady) begin
      msgValid <= evtPending;
      if (evtPending) begin
        msgAssert            <= upAgg[evtLine];
        msgLine              <= evtLine;
        sentState_r[evtLine] <= upAgg[evtLine];
      end
    end
  end

endmodule : switch_port_interrupt_aggregator

// *** verif/sp_intr_asserts.sv ***
// Purpose: port checks of the interrupt aggregator
// Assumes: one clock, synchronous active-high reset
// Notes:   attached by the bind below the module
`timescale 1ns/1ps
`include "switch_port_interrupt_aggregator_params.svh"
module sp_intr_asserts
  import switch_port_interrupt_aggregator_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // events, messages, interrupt
  input wire logic        parityErr,
  input wire logic        cfgReadErr,
  input wire logic        msgValid,
  input wire logic        msgAssert,
  input wire logic [1:0]  msgLine,
  input wire logic        msgReady,
  input wire logic        msiCapListed,
  input wire logic        irq
);
  logic capWr;
  logic wrCycle;
  logic cause;
  assign capWr = pready && pwrite && paddr == `OFS_PM_CAP
                 && pwdata[7:0] == `MSI_CAP_PTR;
  assign wrCycle = psel && pwrite;
  assign cause = parityErr || cfgReadErr || wrCycle;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_stall;
    msgValid && !msgReady;
  endsequence

  a_pready_wait:
    assert property (s_access |=> pready) else $error("pready late");
  a_pready_pulse:
    assert property (pready |=> !pready) else $error("pready too long");
  a_slverr_ready:
    assert property (pslverr |-> pready) else $error("pslverr alone");
  a_rdata_idle:
    assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_msg_hold:
    assert property (s_stall |=> msgValid && $stable(msgLine)
                     && $stable(msgAssert)) else $error("message dropped");
  a_cap_listed:
    assert property ($rose(msiCapListed) |-> $past(capWr)
                     || $past(capWr, 2)) else $error("listed unasked");
  a_irq_cause:
    assert property ($rose(irq) |-> $past(cause) || $past(cause, 2)
                     || $past(cause, 3)) else $error("irq without cause");
  a_irq_fall:
    assert property ($fell(irq) |-> $past(wrCycle) || $past(wrCycle, 2)
                     || $past(wrCycle, 3)) else $error("irq fell alone");
  a_reset_quiet:
    assert property (disable iff (1'b0) rst |=> !msgValid && !irq
                     && !pready && !msiCapListed) else $error("reset");
endmodule : sp_intr_asserts

bind switch_port_interrupt_aggregator sp_intr_asserts u_sp_intr_asserts (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .parityErr(parityErr),
  .cfgReadErr(cfgReadErr), .msgValid(msgValid), .msgAssert(msgAssert),
  .msgLine(msgLine), .msgReady(msgReady), .msiCapListed(msiCapListed),
  .irq(irq)
);

// *** verif/core_msg_sink.sv ***
// Purpose: switch core side taking INTx message requests
// Assumes: a request stands until msgReady at an edge
// Notes:   slow mode accepts one cycle in four
`timescale 1ns/1ps
module core_msg_sink
  import switch_port_interrupt_aggregator_pkg::*;
(
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  rst,
  // message request
  input  wire logic  msgValid,
  input  wire logic  msgAssert,
  input  wire line_t msgLine,
  input  wire logic  slow,
  output logic       msgReady
);
  logic [1:0] stall_r;
  logic [2:0] msgLog[$];
  // stalls prove the request stands until taken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stall_r <= 2'h0;
    end else begin
      stall_r <= stall_r + 2'h1;
    end
  end
  assign msgReady = !slow || stall_r == 2'h3;
  // queue kept for the bench: {assert, line}
  always @(posedge core_clk) begin
    if (!rst && msgValid && msgReady) begin
      msgLog.push_back({msgAssert, msgLine});
    end
  end
endmodule : core_msg_sink

// *** verif/testbench.sv ***
// Purpose: self-checking bench of the interrupt aggregator
// Assumes: core sink model on the message port
// Notes:   one task per scenario
`timescale 1ns/1ps
`include "switch_port_interrupt_aggregator_params.svh"
module testbench
  import switch_port_interrupt_aggregator_pkg::*;
;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        parityErr, cfgReadErr, usMsiReq, slow;
  logic [3:0]  hotPlugIrq, bwMgmtStatusBit, dsLinkUp, dsMsiReq;
  logic [3:0]  autonomousBwStatusBit;
  logic [15:0] rxAssert, rxDeassert;
  logic        msgValid, msgAssert, msgReady, msiCapListed, irq;
  logic [1:0]  msgLine;
  int          numErrors, nCompared;
  // upstream line is the port line minus this distance
  int          swzDist[4] = '{2, 1, 0, 3};

  switch_port_interrupt_aggregator #(
    .NDS(4)
  ) u_switch_port_interrupt_aggregator (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .parityErr(parityErr),
    .cfgReadErr(cfgReadErr), .hotPlugIrq(hotPlugIrq),
    .bwMgmtStatusBit(bwMgmtStatusBit),
    .autonomousBwStatusBit(autonomousBwStatusBit), .dsLinkUp(dsLinkUp),
    .rxAssert(rxAssert), .rxDeassert(rxDeassert), .dsMsiReq(dsMsiReq),
    .usMsiReq(usMsiReq), .msgValid(msgValid), .msgAssert(msgAssert),
    .msgLine(msgLine), .msgReady(msgReady), .msiCapListed(msiCapListed),
    .irq(irq)
  );
  core_msg_sink u_core_msg_sink (
    .core_clk(core_clk), .rst(rst), .msgValid(msgValid),
    .msgAssert(msgAssert), .msgLine(msgLine), .slow(slow),
    .msgReady(msgReady)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask : ticks

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input string what, input logic [7:0] a,
                    input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, x, q);
    check("pslverr", {31'h0, xe}, {31'h0, e});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    check("write pslverr", 32'h0, {31'h0, e});
  endtask : wr

  task automatic msg(input logic [2:0] x);
    int         n;
    logic [2:0] got;
    n = 0;
    while (u_core_msg_sink.msgLog.size() == 0 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    got = u_core_msg_sink.msgLog.size() == 0 ? 3'bxxx
          : u_core_msg_sink.msgLog.pop_front();
    check("intx message", {29'h0, x}, {29'h0, got});
  endtask : msg

  task automatic quiet();
    ticks(12);
    check("message count", 32'h0, u_core_msg_sink.msgLog.size());
  endtask : quiet

  task automatic rx(input logic as, input int b);
    @(posedge core_clk);
    if (as) rxAssert <= 16'h1 << b;
    else rxDeassert <= 16'h1 << b;
    @(posedge core_clk);
    rxAssert <= 16'h0;
    rxDeassert <= 16'h0;
  endtask : rx

  task automatic wait_msi(input logic us);
    int n;
    n = 0;
    while ((us ? usMsiReq : dsMsiReq[1]) !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      n++;
    end
    check("msi request", 32'h1, {31'h0, us ? usMsiReq : dsMsiReq[1]});
  endtask : wait_msi

  task automatic t_regs();
    rd("pm cap", `OFS_PM_CAP, 32'h0, 1'b0);
    wr(`OFS_PM_CAP, 32'hD0);
    ticks(3);
    check("listed while locked", 32'h0, msiCapListed);
    wr(`OFS_US_CTRL, 32'h4);
    wr(`OFS_PM_CAP, 32'hD0);
    ticks(3);
    check("listed", 32'h1, msiCapListed);
    rd("pm cap", `OFS_PM_CAP, 32'h1D0, 1'b0);
    rd("unmapped", 8'h24, 32'h0, 1'b1);
    wr(`OFS_US_CTRL, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_swizzle();
    logic [1:0] u;
    for (int p = 0; p < 4; p++) begin
      for (int l = 0; l < 4; l++) begin
        u = 2'(l - swzDist[p]);
        slow <= 1'(p);
        rx(1'b1, 4 * p + l);
        msg({1'b1, u});
        rd("us status", `OFS_US_INTR_STS, 32'h1 << u, 1'b0);
        rd("ds status", `OFS_DS_INTR_STS, 32'h1 << (4 * p + l), 1'b0);
        rx(1'b0, 4 * p + l);
        msg({1'b0, u});
      end
    end
    slow <= 1'b0;
    quiet();
    $display("test swizzle done");
  endtask : t_swizzle

  task automatic t_or();
    rx(1'b1, 8);
    msg(3'b100);
    rx(1'b1, 2);
    quiet();
    rx(1'b0, 8);
    quiet();
    rd("us status", `OFS_US_INTR_STS, 32'h1, 1'b0);
    @(posedge core_clk);
    dsLinkUp <= 4'hE;
    msg(3'b000);
    rd("ds status", `OFS_DS_INTR_STS, 32'h0, 1'b0);
    dsLinkUp <= 4'hF;
    $display("test or done");
  endtask : t_or

  task automatic t_own();
    @(posedge core_clk);
    hotPlugIrq <= 4'h2;
    msg(3'b111);
    rd("ds own status", `OFS_DS_INTR_STS, 32'h10, 1'b0);
    hotPlugIrq <= 4'h0;
    msg(3'b011);
    wr(`OFS_DS_BW_NOTIFY, 32'h4);
    bwMgmtStatusBit <= 4'h2;
    msg(3'b111);
    bwMgmtStatusBit <= 4'h0;
    msg(3'b011);
    autonomousBwStatusBit <= 4'h2;
    quiet();
    autonomousBwStatusBit <= 4'h0;
    wr(`OFS_DS_MSI_EN, 32'h2);
    hotPlugIrq <= 4'h2;
    wait_msi(1'b0);
    quiet();
    hotPlugIrq <= 4'h0;
    quiet();
    wr(`OFS_DS_MSI_EN, 32'h0);
    wr(`OFS_DS_INTX_DIS, 32'h2);
    hotPlugIrq <= 4'h2;
    quiet();
    hotPlugIrq <= 4'h0;
    quiet();
    wr(`OFS_DS_INTX_DIS, 32'h0);
    $display("test own done");
  endtask : t_own

  task automatic t_err();
    wr(`OFS_IRQ_MASK, 32'h3);
    parityErr <= 1'b1;
    @(posedge core_clk);
    parityErr <= 1'b0;
    ticks(3);
    check("irq", 32'h1, irq);
    msg(3'b100);
    wr(`OFS_IRQ_MASK, 32'h0);
    msg(3'b000);
    check("irq masked", 32'h0, irq);
    wr(`OFS_IRQ_MASK, 32'h3);
    msg(3'b100);
    wr(`OFS_IRQ_STATUS, 32'h1);
    msg(3'b000);
    check("irq cleared", 32'h0, irq);
    wr(`OFS_US_CTRL, 32'h1);
    cfgReadErr <= 1'b1;
    @(posedge core_clk);
    cfgReadErr <= 1'b0;
    wait_msi(1'b1);
    quiet();
    rd("irq status", `OFS_IRQ_STATUS, 32'h2, 1'b0);
    wr(`OFS_IRQ_STATUS, 32'h3);
    wr(`OFS_US_CTRL, 32'h2);
    parityErr <= 1'b1;
    @(posedge core_clk);
    parityErr <= 1'b0;
    quiet();
    check("irq with intx off", 32'h1, irq);
    $display("test errors done");
  endtask : t_err

  task automatic tallyAndFinish();
    $display("compared %0d, mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tallyAndFinish

  initial begin
    {rst, dsLinkUp} = 5'h1F;
    {psel, penable, pwrite, paddr, pwdata, parityErr, cfgReadErr} = '0;
    {hotPlugIrq, bwMgmtStatusBit, autonomousBwStatusBit, slow} = '0;
    {rxAssert, rxDeassert} = '0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_swizzle();
    t_or();
    t_own();
    t_err();
    tallyAndFinish();
  end

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge core_clk);
    numErrors++;
    tallyAndFinish();
  end
endmodule : testbench
